/* logic/dacc_consts.svh */
`ifndef DACC_CONSTS_SVH
`define DACC_CONSTS_SVH

// Byte offsets
`define DACC_OFF_CORE_CONTROL   4'h0
`define DACC_OFF_OUTPUT_CONFIG  4'h1
`define DACC_OFF_EVENT_ROUTING  4'h2
`define DACC_OFF_IRQ_MASK_CLEAR 4'h4
`define DACC_OFF_IRQ_MASK_SET   4'h5
`define DACC_OFF_IRQ_FLAGS      4'h6
`define DACC_OFF_CROSSING_STATE 4'h7
`define DACC_OFF_CONV_VALUE     4'h8
`define DACC_OFF_STAGING_BUFFER 4'hC

// core_control fields
`define DACC_CC_SOFT_RESET      0
`define DACC_CC_ENABLE          1
`define DACC_CC_STANDBY_RUN     2
// output_config fields
`define DACC_OC_EXT_OUT_EN      0
`define DACC_OC_INT_OUT_EN      1
`define DACC_OC_LEFT_ALIGN      2
`define DACC_OC_PUMP_DISABLE    3
`define DACC_OC_REF_LO          6
// event_routing fields
`define DACC_EV_TRIGGER_IN_EN   0
`define DACC_EV_DRAINED_OUT_EN  1
// irq bits
`define DACC_IRQ_STARVED        0
`define DACC_IRQ_DRAINED        1
`define DACC_IRQ_CROSSING_DONE  2
// crossing_state fields
`define DACC_ST_PENDING         7

// Reference select codes
`define DACC_REF_INTERNAL       2'h0
`define DACC_REF_ANALOG_SUPPLY  2'h1
`define DACC_REF_EXTERNAL       2'h2

// Reset values
`define DACC_RST_BYTE           8'h00
`define DACC_RST_WORD           16'h0000

// Timing and sizes
`define DACC_SYNC_CYCLES        4
`define DACC_FIFO_DEPTH         8
`define DACC_VALUE_BITS         10

`endif

/* logic/dacc_pkg.sv */
package dacc_pkg;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } dacc_bus_req_type;

    typedef struct packed {
        logic [1:0] ref_sel;
        logic [1:0] unused;
        logic       pump_disable;
        logic       left_align;
        logic       internal_out_en;
        logic       external_out_en;
    } dacc_outcfg_type;

    typedef enum logic [1:0] {
        SYNC_IDLE,
        SYNC_ENABLE,
        SYNC_RESET
    } dacc_sync_state_type;

endpackage

/* logic/dacc_top.sv */
`timescale 1ns/10ps
`include "dacc_consts.svh"

module dacc_fifo
    import dacc_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = `DACC_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             i_clear,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("dacc_fifo depth must be a power of two");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wptr_reg;
    logic [AW:0]      rptr_reg;
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;

    assign o_level = wptr_reg - rptr_reg;
    assign o_ready = (o_level != DEPTH[AW:0]);
    assign o_valid = (o_level != '0);
    assign o_data  = mem[rptr_reg[AW-1:0]];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else if (i_clear) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
        end else begin
            if (push) wptr_reg <= wptr_reg + 1'b1;
            if (pop)  rptr_reg <= rptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) mem[wptr_reg[AW-1:0]] <= i_data;
    end
endmodule // dacc_fifo

//Contract
// - Soft reset restores registers, disables converter
// - Soft reset write discards other changes
// - Reset bit and pending read one together
// - Writing zero to reset does nothing
// - Enable reads back now, applies later
// - Enable bit shows written target state
// - Standby without run disables output buffer
// - Standby run bit written without crossing
// - Two-bit field selects conversion reference
// - Pump automatic unless pump disable set
// - Left align selects value placement
// - Internal output enable routes to comparator
// - External output enable drives pin buffer
// - Output config writable only when disabled
// - Byte, half and word accesses supported
// - Access guard blocks protected register writes
// - Drained flag set when last entry moves, cleared
// - Starved flag on trigger with empty buffer
// - Trigger resynchronized, buffer copied, conversion starts
// - Synchronized write while pending raises error
module dacc_top
    import dacc_pkg::*;
#(
    parameter int SYNC_CYCLES = `DACC_SYNC_CYCLES,
    parameter int FIFO_DEPTH  = `DACC_FIFO_DEPTH
) (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_B,
    input  wire logic        i_WR,
    input  wire logic        i_RD,
    input  wire logic [3:0]  i_ADDR,
    input  wire logic [3:0]  i_BE,
    input  wire logic [31:0] i_WDATA,
    input  wire logic        i_GUARD_LOCK,
    input  wire logic        i_START_EVENT,
    input  wire logic        i_STANDBY,
    input  wire logic        i_LOW_SUPPLY,
    output logic [31:0]      o_RDATA,
    output logic             o_RVALID,
    output logic             o_SYNC_ERROR,
    output logic             o_IRQ,
    output logic             o_DRAINED_EVENT,
    output logic             o_CONV_START,
    output logic [9:0]       o_CONV_VALUE,
    output logic [1:0]       o_REF_SEL,
    output logic             o_PUMP_ON,
    output logic             o_INT_OUT_EN,
    output logic             o_EXT_BUF_EN,
    output logic             o_CONV_ACTIVE
);
    generate
        if (SYNC_CYCLES < 1 || SYNC_CYCLES > 255) begin : g_bad_sync
            $error("dacc_top SYNC_CYCLES out of range");
        end
    endgenerate

    localparam logic [7:0] SYNC_LOAD = SYNC_CYCLES[7:0];
    localparam int         LW        = $clog2(FIFO_DEPTH);

    logic [1:0]          rst_sync_reg;
    wire                 rst_b = rst_sync_reg[1];
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) rst_sync_reg <= 2'b00;
        else          rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    dacc_bus_req_type    req;
    assign req = '{wr: i_WR, rd: i_RD, addr: i_ADDR, be: i_BE, wdata: i_WDATA};

    // Lane hit within the addressed aligned word
    function automatic logic lane_hit(input dacc_bus_req_type r, input logic [3:0] off);
        lane_hit = (r.addr[3:2] == off[3:2]) && r.be[off[1:0]];
    endfunction
    function automatic logic [7:0] lane_byte(input dacc_bus_req_type r, input logic [3:0] off);
        lane_byte = r.wdata[{off[1:0], 3'b000} +: 8];
    endfunction

    logic                soft_reset_bit_reg;
    logic                enable_reg;
    logic                active_reg;
    logic                standby_run_reg;
    dacc_outcfg_type     outcfg_reg;
    logic [1:0]          routing_reg;
    logic [2:0]          mask_reg;
    logic [2:0]          flags_reg;
    logic                pending_reg;
    dacc_sync_state_type sync_state_reg;
    logic [7:0]          sync_cnt_reg;
    logic [15:0]         data_reg;
    logic [2:0]          evt_sync_reg;

    wire       wr_ok    = req.wr && !i_GUARD_LOCK;
    wire       cc_hit   = wr_ok && lane_hit(req, `DACC_OFF_CORE_CONTROL);
    wire [7:0] cc_byte  = lane_byte(req, `DACC_OFF_CORE_CONTROL);
    wire       rst_wr   = cc_hit && cc_byte[`DACC_CC_SOFT_RESET];
    wire       other_ok = wr_ok && !rst_wr;
    wire       en_wr    = other_ok && cc_hit && (cc_byte[`DACC_CC_ENABLE] != enable_reg);
    wire       sync_err = (rst_wr || en_wr) && pending_reg;
    wire       rst_go   = rst_wr && !pending_reg;
    wire       en_go    = en_wr && !pending_reg;
    wire       sync_end = (sync_state_reg != SYNC_IDLE) && (sync_cnt_reg == 8'h01);
    wire       soft_clr = sync_end && (sync_state_reg == SYNC_RESET);

    wire oc_wr   = other_ok && lane_hit(req, `DACC_OFF_OUTPUT_CONFIG) && !enable_reg
                   && !active_reg;
    wire ev_wr   = other_ok && lane_hit(req, `DACC_OFF_EVENT_ROUTING);
    wire mc_wr   = other_ok && lane_hit(req, `DACC_OFF_IRQ_MASK_CLEAR);
    wire ms_wr   = other_ok && lane_hit(req, `DACC_OFF_IRQ_MASK_SET);
    wire fl_wr   = other_ok && lane_hit(req, `DACC_OFF_IRQ_FLAGS);
    wire dl_wr   = other_ok && lane_hit(req, `DACC_OFF_CONV_VALUE);
    wire dh_wr   = other_ok && lane_hit(req, `DACC_OFF_CONV_VALUE + 4'h1);
    wire sl_wr   = other_ok && lane_hit(req, `DACC_OFF_STAGING_BUFFER);
    wire sh_wr   = other_ok && lane_hit(req, `DACC_OFF_STAGING_BUFFER + 4'h1);
    wire [7:0] fl_byte = lane_byte(req, `DACC_OFF_IRQ_FLAGS);
    wire [7:0] ev_byte = lane_byte(req, `DACC_OFF_EVENT_ROUTING);

    wire trig      = evt_sync_reg[1] && !evt_sync_reg[2];
    wire trig_en   = trig && routing_reg[`DACC_EV_TRIGGER_IN_EN] && active_reg;

    wire              fifo_ready;
    wire              fifo_valid;
    wire [15:0]       fifo_head;
    wire [LW:0]       fifo_level;
    wire              stage_push = sl_wr || sh_wr;
    // Staging halves sit in lanes 0 and 1
    wire [15:0]       stage_word = {sh_wr ? req.wdata[15:8] : 8'h00,
                                    sl_wr ? req.wdata[7:0]  : 8'h00};
    wire              pop        = trig_en && fifo_valid;
    wire              starve_set = trig_en && !fifo_valid;
    wire              drain_set  = pop && (fifo_level == {{LW{1'b0}}, 1'b1});
    wire              data_load  = dl_wr || dh_wr || pop;

    dacc_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_stage_fifo (
        .clk     (I_MCLK),
        .rst_b   (rst_b),
        .i_clear (soft_clr),
        .i_valid (stage_push),
        .o_ready (fifo_ready),
        .i_data  (stage_word),
        .o_valid (fifo_valid),
        .i_ready (pop),
        .o_data  (fifo_head),
        .o_level (fifo_level)
    );

    wire [2:0] flag_set = {sync_end && (sync_state_reg == SYNC_ENABLE), drain_set, starve_set};
    wire [2:0] flag_clr = (fl_wr ? fl_byte[2:0] : 3'b000)
                          | {1'b0, stage_push, 1'b0};
    wire [2:0] flags_next = flag_set | (flags_reg & ~flag_clr);
    wire [7:0] ms_byte    = ms_wr ? lane_byte(req, `DACC_OFF_IRQ_MASK_SET) : 8'h00;
    wire [7:0] mc_byte    = mc_wr ? lane_byte(req, `DACC_OFF_IRQ_MASK_CLEAR) : 8'h00;
    // Upper mask bits unimplemented
    wire [2:0] mask_next  = (mask_reg | ms_byte[2:0]) & ~mc_byte[2:0];
    wire [15:0] data_next = {dh_wr ? req.wdata[15:8] : (pop ? fifo_head[15:8] : data_reg[15:8]),
                             dl_wr ? req.wdata[7:0]  : (pop ? fifo_head[7:0]  : data_reg[7:0])};

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) evt_sync_reg <= 3'b000;
        else        evt_sync_reg <= {evt_sync_reg[1:0], i_START_EVENT};
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            sync_state_reg <= SYNC_IDLE;
            sync_cnt_reg   <= 8'h00;
            pending_reg    <= 1'b0;
        end else if (rst_go || en_go) begin
            sync_state_reg <= rst_go ? SYNC_RESET : SYNC_ENABLE;
            sync_cnt_reg   <= SYNC_LOAD;
            pending_reg    <= 1'b1;
        end else if (sync_end) begin
            sync_state_reg <= SYNC_IDLE;
            sync_cnt_reg   <= 8'h00;
            pending_reg    <= 1'b0;
        end else if (sync_state_reg != SYNC_IDLE) begin
            sync_cnt_reg   <= sync_cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            soft_reset_bit_reg <= 1'b0;
            enable_reg         <= 1'b0;
            active_reg         <= 1'b0;
            standby_run_reg    <= 1'b0;
            outcfg_reg         <= `DACC_RST_BYTE;
            routing_reg        <= 2'b00;
            mask_reg           <= 3'b000;
            flags_reg          <= 3'b000;
            data_reg           <= `DACC_RST_WORD;
        end else if (soft_clr) begin
            // Soft reset lands only once the crossing is done
            soft_reset_bit_reg <= 1'b0;
            enable_reg         <= 1'b0;
            active_reg         <= 1'b0;
            standby_run_reg    <= 1'b0;
            outcfg_reg         <= `DACC_RST_BYTE;
            routing_reg        <= 2'b00;
            mask_reg           <= 3'b000;
            flags_reg          <= 3'b000;
            data_reg           <= `DACC_RST_WORD;
        end else begin
            if (rst_go) soft_reset_bit_reg <= 1'b1;
            if (en_go) enable_reg <= cc_byte[`DACC_CC_ENABLE];
            if (sync_end) active_reg <= enable_reg;
            if (other_ok && cc_hit) standby_run_reg <= cc_byte[`DACC_CC_STANDBY_RUN];
            if (oc_wr) outcfg_reg <= lane_byte(req, `DACC_OFF_OUTPUT_CONFIG);
            if (ev_wr) routing_reg <= ev_byte[1:0];
            mask_reg  <= mask_next;
            flags_reg <= flags_next;
            data_reg  <= data_next;
        end
    end

    wire [7:0] cc_read = {5'h00, standby_run_reg, enable_reg, soft_reset_bit_reg};
    wire [31:0] rd_mux =
        (req.addr[3:2] == 2'h0) ? {8'h00, 6'h00, routing_reg, outcfg_reg, cc_read} :
        (req.addr[3:2] == 2'h1) ? {pending_reg, 7'h00, 5'h00, flags_reg, 5'h00, mask_reg,
                                   5'h00, mask_reg} :
        (req.addr[3:2] == 2'h2) ? {16'h0000, data_reg} :
                                  {16'h0000, fifo_valid ? fifo_head : 16'h0000};
    wire [31:0] be_mask = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}}, {8{req.be[0]}}};

    wire [9:0] conv_val = outcfg_reg.left_align ? data_reg[15:6] : data_reg[9:0];
    wire       stby_off = i_STANDBY && !standby_run_reg;

    always_ff @(posedge I_MCLK or negedge rst_b) begin
        if (!rst_b) begin
            o_RDATA         <= 32'h0000_0000;
            o_RVALID        <= 1'b0;
            o_SYNC_ERROR    <= 1'b0;
            o_IRQ           <= 1'b0;
            o_DRAINED_EVENT <= 1'b0;
            o_CONV_START    <= 1'b0;
            o_CONV_VALUE    <= 10'h000;
            o_REF_SEL       <= `DACC_REF_INTERNAL;
            o_PUMP_ON       <= 1'b0;
            o_INT_OUT_EN    <= 1'b0;
            o_EXT_BUF_EN    <= 1'b0;
            o_CONV_ACTIVE   <= 1'b0;
        end else begin
            o_RDATA         <= req.rd ? (rd_mux & be_mask) : 32'h0000_0000;
            o_RVALID        <= req.rd;
            o_SYNC_ERROR    <= sync_err || (stage_push && !fifo_ready);
            o_IRQ           <= |(flags_reg & mask_reg);
            o_DRAINED_EVENT <= drain_set && routing_reg[`DACC_EV_DRAINED_OUT_EN];
            o_CONV_START    <= data_load && active_reg;
            o_CONV_VALUE    <= conv_val;
            o_REF_SEL       <= outcfg_reg.ref_sel;
            o_PUMP_ON       <= active_reg && !outcfg_reg.pump_disable && i_LOW_SUPPLY;
            o_INT_OUT_EN    <= active_reg && outcfg_reg.internal_out_en;
            o_EXT_BUF_EN    <= active_reg && outcfg_reg.external_out_en && !stby_off;
            o_CONV_ACTIVE   <= active_reg;
        end
    end
endmodule // dacc_top

/* verif/dacc_chk_asserts.sv */
`timescale 1ns/10ps
module dacc_chk #(
    parameter int SYNC_CYCLES = 4,
    parameter int FIFO_DEPTH  = 8
) (
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_B,
    input  wire logic        i_WR,
    input  wire logic        i_RD,
    input  wire logic        i_GUARD_LOCK,
    input  wire logic        i_LOW_SUPPLY,
    input  wire logic [31:0] o_RDATA,
    input  wire logic        o_RVALID,
    input  wire logic        o_SYNC_ERROR,
    input  wire logic        o_CONV_START,
    input  wire logic        o_PUMP_ON,
    input  wire logic        o_INT_OUT_EN,
    input  wire logic        o_EXT_BUF_EN,
    input  wire logic        o_CONV_ACTIVE
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    chk_read_answer: assert property (i_RD |=> o_RVALID)
        else $error("read not answered");
    chk_idle_quiet: assert property (!i_RD |=> !o_RVALID && o_RDATA == 32'h0000_0000)
        else $error("read data outside a read");
    chk_error_cause: assert property (o_SYNC_ERROR |-> $past(i_WR) || $past(i_WR, 2))
        else $error("error pulse without write");
    chk_guard_no_error: assert property (i_WR && i_GUARD_LOCK |=> !o_SYNC_ERROR)
        else $error("locked write flagged error");
    chk_pump_supply: assert property (o_PUMP_ON |-> $past(i_LOW_SUPPLY))
        else $error("pump on without low supply");
    chk_int_out_run: assert property (o_INT_OUT_EN |-> o_CONV_ACTIVE)
        else $error("internal path while stopped");
    chk_ext_buf_run: assert property (o_EXT_BUF_EN |-> o_CONV_ACTIVE)
        else $error("buffer on while stopped");
    chk_start_run: assert property (o_CONV_START |-> o_CONV_ACTIVE)
        else $error("conversion start while stopped");
    cover property (o_CONV_START);
    cover property (o_SYNC_ERROR);
    cover property (o_PUMP_ON && o_EXT_BUF_EN);
endmodule // dacc_chk

bind dacc_top dacc_chk #(.SYNC_CYCLES(SYNC_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk_u (
    .I_MCLK, .I_RST_B, .i_WR, .i_RD, .i_GUARD_LOCK, .i_LOW_SUPPLY, .o_RDATA, .o_RVALID,
    .o_SYNC_ERROR, .o_CONV_START, .o_PUMP_ON, .o_INT_OUT_EN, .o_EXT_BUF_EN, .o_CONV_ACTIVE);

/* verif/dacc_host.sv */
`timescale 1ns/10ps
module dacc_host (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_sync_error,
    output logic             o_wr,
    output logic             o_rd,
    output logic [3:0]       o_addr,
    output logic [3:0]       o_be,
    output logic [31:0]      o_wdata,
    output logic             o_start_event
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 4'h0;
        o_be = 4'h0;
        o_wdata = 32'h0000_0000;
        o_start_event = 1'b0;
    end
    // Error may land one or two cycles on
    task automatic write(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d,
                         output logic err);
        @(posedge i_clk);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_be    <= b;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        o_wdata <= ~d;
        #1;
        err = i_sync_error;
        @(posedge i_clk);
        #1;
        err = err | i_sync_error;
    endtask
    task automatic read(input logic [3:0] a, input logic [3:0] b, output logic [31:0] d);
        @(posedge i_clk);
        o_rd   <= 1'b1;
        o_addr <= a;
        o_be   <= b;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
    task automatic trigger();
        @(posedge i_clk);
        o_start_event <= 1'b1;
        repeat (6) @(posedge i_clk);
        o_start_event <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask
endmodule // dacc_host

/* verif/tb.sv */
`timescale 1ns/10ps
module tb;
    typedef struct {
        logic [3:0] a; logic [3:0] wb; logic [31:0] wd; logic [3:0] rb; logic [31:0] ex;
    } dacc_row_type;
    logic        clk, rst_b, guard, standby, low_sup, wr, rd, ev, serr, active;
    logic        ext_en, int_en, pump_on, irq, e;
    logic        conv_start, drained, rvalid;
    logic [3:0]  addr, be;
    logic [1:0]  ref_sel;
    logic [9:0]  conv_value;
    logic [31:0] wdata, rdata, d;
    int          miscompares = 0;
    int          comparisons = 0;
    int          reads       = 0;
    int          answers     = 0;
    int          starts      = 0;
    int          drains      = 0;
    dacc_row_type rows [7] = '{
        '{4'h0, 4'h1, 32'h0000_0004, 4'h1, 32'h0000_0004},
        '{4'h0, 4'h2, 32'h0000_8700, 4'h2, 32'h0000_8700},
        '{4'h0, 4'h4, 32'h0003_0000, 4'h4, 32'h0003_0000},
        '{4'h4, 4'h2, 32'h0000_0700, 4'h1, 32'h0000_0007},
        '{4'h4, 4'h1, 32'h0000_0005, 4'h2, 32'h0000_0200},
        '{4'h8, 4'h3, 32'h0000_1234, 4'h3, 32'h0000_1234},
        '{4'h8, 4'h2, 32'h0000_5600, 4'h3, 32'h0000_5634}};
    dacc_host host_u (.i_clk(clk), .i_rdata(rdata), .i_sync_error(serr), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_be(be), .o_wdata(wdata), .o_start_event(ev));
    // Longer crossing widens the pending window
    dacc_top #(.SYNC_CYCLES(8), .FIFO_DEPTH(8)) dut_u (.I_MCLK(clk), .I_RST_B(rst_b),
        .i_WR(wr), .i_RD(rd), .i_ADDR(addr), .i_BE(be), .i_WDATA(wdata),
        .i_GUARD_LOCK(guard), .i_START_EVENT(ev), .i_STANDBY(standby),
        .i_LOW_SUPPLY(low_sup), .o_RDATA(rdata), .o_RVALID(rvalid), .o_SYNC_ERROR(serr),
        .o_IRQ(irq), .o_DRAINED_EVENT(drained), .o_CONV_START(conv_start),
        .o_CONV_VALUE(conv_value),
        .o_REF_SEL(ref_sel), .o_PUMP_ON(pump_on), .o_INT_OUT_EN(int_en),
        .o_EXT_BUF_EN(ext_en), .o_CONV_ACTIVE(active));
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] ex, input string m);
        comparisons++;
        if (got !== ex) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, ex);
        end
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        for (int n = 0; n < 40; n++) begin
            host_u.read(4'h4, 4'h8, s);
            if (s[31] === 1'b0) return;
        end
        check(32'h1, 32'h0, "pending stuck");
        conclude();
    endtask
    task automatic edge_set(input int n);
        repeat (n) @(posedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Pulses counted as they pass
    always @(posedge clk) begin
        if (rd === 1'b1) reads++;
        if (rvalid === 1'b1) answers++;
        if (conv_start === 1'b1) starts++;
        if (drained === 1'b1) drains++;
    end
    initial begin
        rst_b = 1'b0;
        guard = 1'b0;
        standby = 1'b0;
        low_sup = 1'b0;
        edge_set(10);
        rst_b <= 1'b1;
        edge_set(3);
        host_u.read(4'h0, 4'hF, d);
        check(d, 32'h0, "word0 reset");
        host_u.read(4'h4, 4'hF, d);
        check(d, 32'h0, "word1 reset");
        foreach (rows[i]) begin
            host_u.write(rows[i].a, rows[i].wb, rows[i].wd, e);
            host_u.read(rows[i].a, rows[i].rb, d);
            check(d, rows[i].ex, "row readback");
        end
        check({22'h0, conv_value}, 32'h0000_0158, "left aligned value");
        check({30'h0, ref_sel}, 32'h2, "reference code");
        host_u.write(4'h0, 4'h1, 32'h0000_0006, e);
        host_u.read(4'h4, 4'h8, d);
        check(d, 32'h8000_0000, "pending after enable");
        host_u.write(4'h0, 4'h1, 32'h0000_0004, e);
        check({31'h0, e}, 32'h1, "write while pending");
        host_u.read(4'h0, 4'h1, d);
        check(d, 32'h0000_0006, "enable readback");
        wait_idle();
        @(posedge clk);
        low_sup <= 1'b1;
        edge_set(3);
        check({28'h0, active, ext_en, int_en, pump_on}, 32'hF, "running outputs");
        host_u.read(4'h4, 4'h4, d);
        check(d, 32'h0004_0000, "crossing done flag");
        host_u.write(4'h4, 4'h2, 32'h0000_0400, e);
        edge_set(2);
        check({31'h0, irq}, 32'h1, "irq masked in");
        host_u.write(4'h4, 4'h4, 32'h0004_0000, e);
        edge_set(2);
        check({31'h0, irq}, 32'h0, "irq after clear");
        @(posedge clk);
        standby <= 1'b1;
        edge_set(3);
        check({31'h0, ext_en}, 32'h1, "standby run keeps buffer");
        host_u.write(4'h0, 4'h1, 32'h0000_0002, e);
        edge_set(2);
        check({31'h0, ext_en}, 32'h0, "standby drops buffer");
        host_u.read(4'h4, 4'h8, d);
        check(d, 32'h0, "standby bit not pending");
        @(posedge clk);
        standby <= 1'b0;
        host_u.write(4'h0, 4'h2, 32'h0000_0000, e);
        host_u.read(4'h0, 4'h2, d);
        check(d, 32'h0000_8700, "config locked while on");
        @(posedge clk);
        guard <= 1'b1;
        host_u.write(4'h0, 4'h4, 32'h0000_0000, e);
        @(posedge clk);
        guard <= 1'b0;
        host_u.read(4'h0, 4'h4, d);
        check(d, 32'h0003_0000, "guarded write ignored");
        for (int k = 1; k <= 9; k++) begin
            host_u.write(4'hC, 4'h3, 32'h0000_0040 * k, e);
        end
        check({31'h0, e}, 32'h1, "full buffer refused");
        for (int k = 1; k <= 8; k++) begin
            host_u.trigger();
            check({22'h0, conv_value}, k, "event value");
        end
        check(starts, 32'h8, "start pulses");
        check(drains, 32'h1, "drained event");
        host_u.read(4'h4, 4'h4, d);
        check(d, 32'h0002_0000, "drained flag");
        host_u.write(4'h4, 4'h4, 32'h0002_0000, e);
        host_u.trigger();
        host_u.read(4'h4, 4'h4, d);
        check(d, 32'h0001_0000, "starved flag only");
        host_u.write(4'h0, 4'h7, 32'h0000_FF05, e);
        host_u.read(4'h0, 4'h7, d);
        check(d & 32'h00FF_FF05, 32'h0003_8701, "reset ongoing");
        wait_idle();
        host_u.read(4'h0, 4'hF, d);
        check(d, 32'h0, "registers cleared");
        check({31'h0, active}, 32'h0, "converter stopped");
        host_u.write(4'h0, 4'h2, 32'h0000_0800, e);
        host_u.write(4'h0, 4'h1, 32'h0000_0002, e);
        wait_idle();
        edge_set(2);
        check({30'h0, active, pump_on}, 32'h2, "pump held off");
        check(answers, reads, "read answers");
        conclude();
    end
endmodule // tb
